//--- hdl/efd_pkg.sv
// Shared constants and types for the earth-fault logger and phase classifier.
// Assumes one clock domain and a plain strobe-based register port.
package efd_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int REC_DEPTH = 8;            // Latest faults kept
  localparam int REC_AW    = 3;
  localparam int CUR_W     = 16;           // Currents, per-unit of nominal
  localparam int ANG_W     = 10;           // Signed whole degrees
  localparam int BUS_AW    = 8;
  localparam int BUS_DW    = 32;
  localparam int CNT_W     = 4;
  localparam int GRP_W     = 2;            // Setting group 1..4 coded 0..3
  localparam int NPH       = 3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ       = 250000000;
  localparam longint LOAD_AVG_MS  = 1000;  // Pre-fault load averaging window
  localparam longint LOAD_AVG_CYC = LOAD_AVG_MS * CLK_HZ / 1000;

  // ---------------------------------------------------------------
  // Angles, at ANG_W+1 bits for intermediate sums
  // ---------------------------------------------------------------
  localparam logic signed [ANG_W:0] DEG_60  = 11'sh03C;
  localparam logic signed [ANG_W:0] DEG_90  = 11'sh05A;
  localparam logic signed [ANG_W:0] DEG_180 = 11'sh0B4;
  localparam logic signed [ANG_W:0] DEG_360 = 11'sh168;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses) and control fields
  // ---------------------------------------------------------------
  localparam logic [BUS_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [BUS_AW-1:0] OFS_DELTA  = 8'h04;
  localparam logic [BUS_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [BUS_AW-1:0] OFS_ACLR   = 8'h0C;
  localparam logic [BUS_AW-1:0] OFS_RDSEL  = 8'h10;
  localparam logic [BUS_AW-1:0] OFS_DATE   = 8'h20;
  localparam logic [BUS_AW-1:0] OFS_TIME   = 8'h24;
  localparam logic [BUS_AW-1:0] OFS_TYPE   = 8'h28;
  localparam logic [BUS_AW-1:0] OFS_CUR    = 8'h2C;
  localparam logic [BUS_AW-1:0] OFS_ANG    = 8'h30;
  localparam int CTRL_REC_LSB = 0;         // Stages 2..4 record enables
  localparam int CTRL_CAP_LSB = 4;         // Groups 1..4 capacitive select
  localparam logic [BUS_DW-1:0] CTRL_RST  = 32'h00000007;
  localparam logic [CUR_W-1:0]  DELTA_RST = 16'h0000;

  // Fault type codes
  typedef enum logic [3:0] {
    FT_NONE = 4'h0, FT_1N = 4'h1, FT_2N = 4'h2, FT_3N = 4'h3,
    FT_12 = 4'h4, FT_23 = 4'h5, FT_31 = 4'h6, FT_123 = 4'h7,
    FT_12N = 4'h8, FT_23N = 4'h9, FT_31N = 4'hA, FT_123N = 4'hB
  } efd_fault_type_e;

  // Direction mode of the recording stage
  typedef enum logic [1:0] {
    DM_DIR = 2'h0, DM_UNDIR = 2'h1, DM_DIR_BACKUP = 2'h2
  } efd_dir_mode_e;

  // Classifier sequence, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SUSPECT = 2'b01, ST_CONFIRM = 2'b11, ST_HOLD = 2'b10
  } efd_state_e;

  // One fault record
  typedef struct packed {
    logic [31:0]             date;
    logic [31:0]             tod;
    efd_fault_type_e         ftype;
    logic                    efReverse;
    logic [CUR_W-1:0]        faultCur;
    logic [CUR_W-1:0]        loadCur;
    logic [7:0]              elapsedDelayPct;
    logic signed [ANG_W-1:0] angle;
    logic [CUR_W-1:0]        positiveSeqVoltage;
    logic [GRP_W-1:0]        activeSettingGroup;
    efd_dir_mode_e           dirMode;
  } efd_rec_s;
endpackage

//--- hdl/efd_record_mem.sv
// Small record store: one write port, one registered read port.
// Assumes the writer and reader share ref_clk and its clock enable.
module efd_record_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          ref_clk,
  input  wire logic          clkEn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] store [DEPTH];

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (clkEn && we) begin
      store[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      rdata <= store[raddr];
    end
  end
endmodule

//--- hdl/efd_earth_fault_logger.sv
// Fault record logger and earth-fault faulted-phase classifier.
// Assumes measurement inputs come from front-end logic on ref_clk.
// Summary of operation
// - Keep records of the eight latest faults
// - Stamp each record with date and time
// - Fault type is one of eleven codes
// - Store peak current and 1-s pre-fault load
// - Store elapsed operate-time percent, 100 trips
// - Store angle, voltage, setting group, direction mode
// - Start on residual overcurrent; delta, then angle
// - Phase one: 0 forward, 180 reverse
// - Phase two: -120 forward, 60 reverse
// - Phase three: -60 reverse
// - Identified phase logs, raises event and alarm
// - Stages two to four enable phase recording
// - Per-group grounding select, resistive by default
// - Capacitive: rotate residual angle 90 inductive
// - One rising phase within 60 degrees: forward
// - Two rising, angle between them: forward
// - All three rising: forward three-phase
// - Falling phase count gives reverse class
//
// The strobed register port and the register offsets were decided locally.
module efd_earth_fault_logger
  import efd_pkg::*;
#(
  parameter longint LOAD_WIN = efd_pkg::LOAD_AVG_CYC
) (
  input  wire logic                                   ref_clk,
  input  wire logic                                   rst,
  input  wire logic                                   clkEn,
  input  wire logic [efd_pkg::BUS_AW-1:0]              addr,
  input  wire logic [efd_pkg::BUS_DW-1:0]              wdata,
  input  wire logic                                   wr,
  input  wire logic                                   rd,
  output logic      [efd_pkg::BUS_DW-1:0]              rdata,
  input  wire logic [31:0]                            dateStamp,
  input  wire logic [31:0]                            timeStamp,
  input  wire logic [efd_pkg::NPH*efd_pkg::CUR_W-1:0]  phaseCur,
  input  wire logic [efd_pkg::NPH*efd_pkg::CUR_W-1:0]  phaseDelta,
  input  wire logic [efd_pkg::NPH*efd_pkg::ANG_W-1:0]  phaseAng,
  input  wire logic signed [efd_pkg::ANG_W-1:0]       residualAng,
  input  wire logic                                   residualOc,
  input  wire logic [efd_pkg::CUR_W-1:0]               positive_seq_voltage,
  input  wire logic [efd_pkg::GRP_W-1:0]               active_setting_group,
  input  wire logic [2:0]                             efStagePickup,
  input  wire logic                                   stageStart,
  input  wire logic                                   recordReq,
  input  wire efd_pkg::efd_fault_type_e               recordType,
  input  wire logic [7:0]                             elapsed_delay_pct,
  input  wire logic signed [efd_pkg::ANG_W-1:0]       faultAng,
  input  wire efd_pkg::efd_dir_mode_e                 dirMode,
  output logic      [1:0]                             forward_fault_class,
  output logic      [1:0]                             reverse_fault_class,
  output logic      [efd_pkg::NPH-1:0]                 faultedPhases,
  output logic                                        efEvent,
  output logic                                        efAlarm
);
  import efd_pkg::*;

  // ---------------------------------------------------------------
  // Angle helpers
  // ---------------------------------------------------------------
  // Fold a sum into -180..179 degrees
  function automatic logic signed [ANG_W-1:0] wrapAng(input logic signed [ANG_W:0] a);
    logic signed [ANG_W:0] r;
    r = a;
    if (r >= DEG_180) begin
      r = r - DEG_360;
    end else if (r < -DEG_180) begin
      r = r + DEG_360;
    end
    return r[ANG_W-1:0];
  endfunction

  // True when a lies within 60 degrees of b
  function automatic logic nearAng(input logic signed [ANG_W-1:0] a,
                                   input logic signed [ANG_W-1:0] b);
    logic signed [ANG_W:0] d;
    d = (ANG_W+1)'(wrapAng((ANG_W+1)'(a) - (ANG_W+1)'(b)));
    d = {d[ANG_W-1], d[ANG_W-1:0]};
    return (d <= DEG_60) && (d >= -DEG_60);
  endfunction

  // Phase set to fault type with earth contact
  function automatic efd_fault_type_e typeOf(input logic [NPH-1:0] m);
    case (m)
      3'b001:  return FT_1N;
      3'b010:  return FT_2N;
      3'b100:  return FT_3N;
      3'b011:  return FT_12N;
      3'b110:  return FT_23N;
      3'b101:  return FT_31N;
      3'b111:  return FT_123N;
      default: return FT_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [BUS_DW-1:0]  ctrl;
  logic [CUR_W-1:0]   deltaLimit;
  logic [REC_AW-1:0]  rdSel;
  logic               alarmClr;

  // Control, delta limit and record select writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl       <= CTRL_RST;
      deltaLimit <= DELTA_RST;
      rdSel      <= '0;
    end else if (clkEn && wr) begin
      if (addr == OFS_CTRL) ctrl <= wdata;
      if (addr == OFS_DELTA) deltaLimit <= wdata[CUR_W-1:0];
      if (addr == OFS_RDSEL) rdSel <= wdata[REC_AW-1:0];
    end
  end

  assign alarmClr = wr && (addr == OFS_ACLR) && wdata[0];

  // Recording allowed when a picked-up stage has it enabled
  logic recEnable;
  logic capSel;
  assign recEnable = |(efStagePickup & ctrl[CTRL_REC_LSB +: 3]);
  assign capSel    = ctrl[CTRL_CAP_LSB + int'(active_setting_group)];

  // ---------------------------------------------------------------
  // Pre-fault load and peak fault current
  // ---------------------------------------------------------------
  logic [CUR_W-1:0] maxNow;
  logic [CUR_W-1:0] peakCur;
  logic [CUR_W-1:0] loadAvg;
  logic [63:0]      loadSum;
  logic [63:0]      loadCnt;
  logic             faultActive;
  logic             faultActiveQ;

  // Largest of the three phase currents this cycle
  always_comb begin
    maxNow = '0;
    for (int i = 0; i < NPH; i++) begin
      if (phaseCur[i*CUR_W +: CUR_W] > maxNow) maxNow = phaseCur[i*CUR_W +: CUR_W];
    end
  end

  assign faultActive = stageStart | residualOc;

  // Peak current held from fault onset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      peakCur      <= '0;
      faultActiveQ <= 1'b0;
    end else if (clkEn) begin
      faultActiveQ <= faultActive;
      if (faultActive && !faultActiveQ) begin
        peakCur <= maxNow;
      end else if (faultActive && maxNow > peakCur) begin
        peakCur <= maxNow;
      end
    end
  end

  // One-second averaging window, frozen during a fault
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loadSum <= '0;
      loadCnt <= '0;
      loadAvg <= '0;
    end else if (clkEn && !faultActive) begin
      if (loadCnt == 64'(LOAD_WIN) - 64'd1) begin
        loadAvg <= CUR_W'((loadSum + 64'(maxNow)) / 64'(LOAD_WIN));
        loadSum <= '0;
        loadCnt <= '0;
      end else begin
        loadSum <= loadSum + 64'(maxNow);
        loadCnt <= loadCnt + 64'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Faulted-phase classifier
  // ---------------------------------------------------------------
  efd_state_e             state;
  efd_state_e             next_state;
  logic [NPH-1:0]         upM;
  logic [NPH-1:0]         dnM;
  logic [NPH-1:0]         upNow;
  logic [NPH-1:0]         dnNow;
  logic signed [ANG_W-1:0] resAdj;
  logic                   hit;
  logic                   hitRev;
  logic [1:0]             hitClass;

  // Delta test per phase
  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      upNow[i] = $signed(phaseDelta[i*CUR_W +: CUR_W]) > $signed({1'b0, deltaLimit});
      dnNow[i] = $signed(phaseDelta[i*CUR_W +: CUR_W]) < -$signed({1'b0, deltaLimit});
    end
  end

  // Capacitive networks lag the residual angle by 90 degrees first
  assign resAdj = capSel ? wrapAng((ANG_W+1)'(residualAng) - DEG_90)
                         : residualAng;

  // Angle confirmation of the latched suspect set
  always_comb begin
    logic signed [ANG_W-1:0] a;
    logic signed [ANG_W-1:0] b;
    logic signed [ANG_W-1:0] mid;
    logic [1:0]              nUp;
    logic [1:0]              nDn;
    a        = '0;
    b        = '0;
    mid      = '0;
    hit      = 1'b0;
    hitRev   = 1'b0;
    nUp      = 2'(upM[0]) + 2'(upM[1]) + 2'(upM[2]);
    nDn      = 2'(dnM[0]) + 2'(dnM[1]) + 2'(dnM[2]);
    hitClass = nUp;
    if (nUp == 2'd3) begin
      hit = 1'b1;
    end else if (nUp != 2'd0 && nDn == 2'd0) begin
      for (int i = 0; i < NPH; i++) begin
        a = phaseAng[i*ANG_W +: ANG_W];
        b = phaseAng[((i+1)%NPH)*ANG_W +: ANG_W];
        if (nUp == 2'd1 && upM[i] && nearAng(resAdj, a)) begin
          hit = 1'b1;
        end
        if (nUp == 2'd2 && upM[i] && upM[(i+1)%NPH]) begin
          mid = wrapAng((ANG_W+1)'(a) + (ANG_W+1)'(wrapAng((ANG_W+1)'(b) - (ANG_W+1)'(a)) >>> 1));
          if (nearAng(resAdj, mid)) hit = 1'b1;
        end
      end
    end else if (nUp == 2'd0 && nDn != 2'd0) begin
      hitRev   = 1'b1;
      hitClass = nDn;
      if (nDn != 2'd1) hit = 1'b1;
      for (int i = 0; i < NPH; i++) begin
        a = wrapAng((ANG_W+1)'(phaseAng[i*ANG_W +: ANG_W]) + DEG_180);
        if (nDn == 2'd1 && dnM[i] && nearAng(resAdj, a)) begin
          hit = 1'b1;
        end
      end
    end
  end

  // Sequence: wait for residual overcurrent, suspect, confirm, hold
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (residualOc && recEnable) next_state = ST_SUSPECT;
      ST_SUSPECT: next_state = ST_CONFIRM;
      ST_CONFIRM: next_state = ST_HOLD;
      ST_HOLD:    if (!residualOc) next_state = ST_IDLE;
    endcase
  end

  // State and latched suspect set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      upM   <= '0;
      dnM   <= '0;
    end else if (clkEn) begin
      state <= next_state;
      if (state == ST_SUSPECT) begin
        upM <= upNow;
        dnM <= dnNow;
      end
    end
  end

  logic efLog;
  assign efLog = (state == ST_CONFIRM) && hit;

  // Result, event pulse and sticky alarm (set beats clear)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      forward_fault_class <= '0;
      reverse_fault_class <= '0;
      faultedPhases       <= '0;
      efEvent             <= 1'b0;
      efAlarm             <= 1'b0;
    end else if (clkEn) begin
      efEvent <= efLog;
      if (efLog) begin
        forward_fault_class <= hitRev ? 2'd0 : hitClass;
        reverse_fault_class <= hitRev ? hitClass : 2'd0;
        faultedPhases       <= hitRev ? dnM : upM;
        efAlarm             <= 1'b1;
      end else if (alarmClr) begin
        efAlarm <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Record log
  // ---------------------------------------------------------------
  logic              pendStage;
  logic [REC_AW-1:0] wrPtr;
  logic [CNT_W-1:0]  recCount;
  logic              memWe;
  efd_rec_s          memWd;
  efd_rec_s          memRd;

  // Stage requests wait while the classifier writes (set beats clear)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pendStage <= 1'b0;
    end else if (clkEn) begin
      if (recordReq) pendStage <= 1'b1;
      else if (!efLog) pendStage <= 1'b0;
    end
  end

  assign memWe = efLog || pendStage;

  // Record contents, stamped at write time
  always_comb begin
    memWd                    = '0;
    memWd.date               = dateStamp;
    memWd.tod                = timeStamp;
    memWd.faultCur           = peakCur;
    memWd.loadCur            = loadAvg;
    memWd.elapsedDelayPct    = elapsed_delay_pct;
    memWd.positiveSeqVoltage = positive_seq_voltage;
    memWd.activeSettingGroup = active_setting_group;
    memWd.dirMode            = dirMode;
    if (efLog) begin
      memWd.ftype     = typeOf(hitRev ? dnM : upM);
      memWd.efReverse = hitRev;
      memWd.angle     = resAdj;
    end else begin
      memWd.ftype = recordType;
      memWd.angle = faultAng;
    end
  end

  // Circular pointer; a full log overwrites the oldest entry
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr    <= '0;
      recCount <= '0;
    end else if (clkEn && memWe) begin
      wrPtr <= wrPtr + REC_AW'(1);
      if (recCount != CNT_W'(REC_DEPTH)) recCount <= recCount + CNT_W'(1);
    end
  end

  efd_record_mem #(
    .W     ($bits(efd_rec_s)),
    .DEPTH (REC_DEPTH),
    .AW    (REC_AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .clkEn   (clkEn),
    .we      (memWe),
    .waddr   (wrPtr),
    .wdata   (memWd),
    .raddr   (wrPtr - REC_AW'(1) - rdSel),
    .rdata   (memRd)
  );

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (clkEn) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          OFS_CTRL:   rdata <= ctrl;
          OFS_DELTA:  rdata <= BUS_DW'(deltaLimit);
          OFS_STATUS: rdata <= {14'h0000, efAlarm, 2'b00, faultedPhases,
                                reverse_fault_class, forward_fault_class,
                                2'b00, 2'(state), recCount};
          OFS_RDSEL:  rdata <= BUS_DW'(rdSel);
          OFS_DATE:   rdata <= memRd.date;
          OFS_TIME:   rdata <= memRd.tod;
          OFS_TYPE:   rdata <= {8'h00, memRd.elapsedDelayPct, 2'b00,
                                memRd.activeSettingGroup, memRd.dirMode, 2'b00,
                                3'b000, memRd.efReverse, 4'(memRd.ftype)};
          OFS_CUR:    rdata <= {memRd.faultCur, memRd.loadCur};
          OFS_ANG:    rdata <= {memRd.positiveSeqVoltage, 6'h00, memRd.angle};
          default:    rdata <= '0;
        endcase
      end
    end
  end
endmodule

//--- testbench/efd_monitor.sv
// Port checker for the earth-fault logger.
// Assumes clkEn held high and a bind onto the logger.
module efd_monitor
  import efd_pkg::*;
(
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       rd,
  input wire logic [efd_pkg::BUS_DW-1:0] rdata,
  input wire logic                       residualOc,
  input wire logic [2:0]                 efStagePickup,
  input wire logic                       efEvent,
  input wire logic                       efAlarm,
  input wire logic [1:0]                 forward_fault_class,
  input wire logic [1:0]                 reverse_fault_class,
  input wire logic [efd_pkg::NPH-1:0]    faultedPhases
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----
  // Classifier outputs and register read data
  // ----
  chk_event_single_pulse: assert property (efEvent |=> !efEvent [*3])
    else $error("event pulse too long");
  chk_alarm_with_event: assert property (efEvent |-> efAlarm)
    else $error("alarm missing at event");
  chk_event_after_oc: assert property (efEvent |-> $past(residualOc, 2))
    else $error("event without residual overcurrent");
  chk_event_stage_up: assert property (efEvent |-> $past(efStagePickup, 2) != 3'h0)
    else $error("event without stage pickup");
  chk_dir_exclusive: assert property (forward_fault_class != 2'h0 |->
    reverse_fault_class == 2'h0)
    else $error("both directions reported");
  chk_class_on_event: assert property ($changed({forward_fault_class,
    reverse_fault_class, faultedPhases}) |-> efEvent)
    else $error("class changed without event");
  chk_fwd_phase_count: assert property (efEvent && forward_fault_class != 2'h0 |->
    $countones(faultedPhases) == forward_fault_class)
    else $error("forward class and mask disagree");
  chk_rev_phase_count: assert property (efEvent && reverse_fault_class != 2'h0 |->
    $countones(faultedPhases) == reverse_fault_class)
    else $error("reverse class and mask disagree");
  chk_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h00000000)
    else $error("read data outside answer cycle");
endmodule

//--- testbench/efd_front_end.sv
// Measurement front-end model: phase deltas, angles and residual current.
// Assumes the bench calls fault() and clear() right after clock edges.
module efd_front_end
  import efd_pkg::*;
(
  input  wire logic                              ref_clk,
  output logic [efd_pkg::NPH*efd_pkg::CUR_W-1:0] phaseCur,
  output logic [efd_pkg::NPH*efd_pkg::CUR_W-1:0] phaseDelta,
  output logic [efd_pkg::NPH*efd_pkg::ANG_W-1:0] phaseAng,
  output logic signed [efd_pkg::ANG_W-1:0]       residualAng,
  output logic                                   residualOc,
  output logic                                   stageStart,
  output logic [2:0]                             efStagePickup,
  output logic [efd_pkg::CUR_W-1:0]              positive_seq_voltage,
  output logic [efd_pkg::GRP_W-1:0]              active_setting_group,
  output logic [31:0]                            dateStamp,
  output logic [31:0]                            timeStamp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Steady grounded network, phases at 0, -120, 120 degrees
  // ----
  initial begin
    phaseCur = {3{16'h0100}};
    phaseDelta = 48'h0;
    phaseAng = {10'h078, 10'h388, 10'h000};
    residualAng = 10'h000;
    residualOc = 1'b0;
    stageStart = 1'b0;
    efStagePickup = 3'h0;
    positive_seq_voltage = 16'h1234;
    active_setting_group = 2'h1;
    dateStamp = 32'h0A0B0C0D;
    timeStamp = 32'h01020304;
  end
  // Residual overcurrent rises together with the phase deltas
  task automatic fault(input logic [2:0] up, dn, input logic [9:0] res);
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      phaseDelta[16*i+:16] <= up[i] ? 16'h0020 : dn[i] ? 16'hFFE0 : 16'h0000;
    end
    residualAng <= res;
    residualOc <= 1'b1;
    stageStart <= 1'b1;
    efStagePickup <= 3'h1;
  endtask
  // Fault gone: deltas settle, overcurrent drops
  task automatic clear();
    @(posedge ref_clk);
    phaseDelta <= 48'h0;
    residualOc <= 1'b0;
    stageStart <= 1'b0;
    efStagePickup <= 3'h0;
  endtask
endmodule

//--- testbench/test_efd_earth_fault_logger.sv
// Self-checking bench for the earth-fault logger and phase classifier.
// Assumes the front-end model and the bound port checker beside it.
module test_efd_earth_fault_logger
  import efd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 ref_clk, rst, clkEn, wr, rd, recordReq;
  logic [BUS_AW-1:0]    addr;
  logic [BUS_DW-1:0]    wdata, rdata;
  logic [31:0]          dateStamp, timeStamp;
  logic [NPH*CUR_W-1:0] phaseCur, phaseDelta;
  logic [NPH*ANG_W-1:0] phaseAng;
  logic signed [9:0]    residualAng, faultAng;
  logic                 residualOc, stageStart, efEvent, efAlarm;
  logic [CUR_W-1:0]     positive_seq_voltage;
  logic [GRP_W-1:0]     active_setting_group;
  logic [2:0]           efStagePickup, faultedPhases;
  efd_fault_type_e      recordType;
  logic [7:0]           elapsed_delay_pct;
  efd_dir_mode_e        dirMode;
  logic [1:0]           forward_fault_class, reverse_fault_class;
  int                   err_total, checks;

  efd_earth_fault_logger #(.LOAD_WIN(16)) u_dut (
    .ref_clk, .rst, .clkEn, .addr, .wdata, .wr, .rd, .rdata, .dateStamp, .timeStamp,
    .phaseCur, .phaseDelta, .phaseAng, .residualAng, .residualOc, .positive_seq_voltage,
    .active_setting_group, .efStagePickup, .stageStart, .recordReq, .recordType,
    .elapsed_delay_pct, .faultAng, .dirMode, .forward_fault_class, .reverse_fault_class,
    .faultedPhases, .efEvent, .efAlarm);
  efd_front_end u_fe (
    .ref_clk, .phaseCur, .phaseDelta, .phaseAng, .residualAng, .residualOc, .stageStart,
    .efStagePickup, .positive_seq_voltage, .active_setting_group, .dateStamp, .timeStamp);
  // ----
  // Clock, verdict and bus helpers
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read answer stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata & m, e);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic reg_defaults();
    rd_reg(OFS_CTRL, CTRL_RST, 32'hFFFFFFFF);
    rd_reg(8'h3C, 32'h0, 32'hFFFFFFFF);
    wr_reg(OFS_DELTA, 32'h00000010);
    rd_reg(OFS_DELTA, 32'h00000010, 32'h0000FFFF);
  endtask
  task automatic run_case(input logic [7:0] c, input logic [2:0] up, dn, input logic [9:0] res,
                          input logic [1:0] fw, rv, input logic [2:0] ph, input logic [3:0] ft);
    logic       hit;
    logic [6:0] cls;
    hit = 1'b0;
    wr_reg(OFS_CTRL, {24'h0, c});
    u_fe.fault(up, dn, res);
    repeat (8) begin
      @(negedge ref_clk);
      if (efEvent === 1'b1) hit = 1'b1;
    end
    cls = {forward_fault_class, reverse_fault_class, faultedPhases};
    chk({31'h0, hit}, {31'h0, |{fw, rv}});
    if (|{fw, rv}) chk({25'h0, cls}, {25'h0, fw, rv, ph});
    u_fe.clear();
    repeat (4) @(posedge ref_clk);
    if (|{fw, rv}) rd_reg(OFS_TYPE, {27'h0, |rv, ft}, 32'h0000001F);
    if (|{fw, rv}) rd_reg(OFS_DATE, 32'h0A0B0C0D, 32'hFFFFFFFF);
  endtask
  task automatic classify();
    run_case(8'h07, 3'h1, 3'h0, 10'h000, 2'h1, 2'h0, 3'h1, FT_1N);
    run_case(8'h07, 3'h2, 3'h0, 10'h388, 2'h1, 2'h0, 3'h2, FT_2N);
    run_case(8'h07, 3'h4, 3'h0, 10'h078, 2'h1, 2'h0, 3'h4, FT_3N);
    run_case(8'h07, 3'h0, 3'h1, 10'h0B4, 2'h0, 2'h1, 3'h1, FT_1N);
    run_case(8'h07, 3'h0, 3'h2, 10'h03C, 2'h0, 2'h1, 3'h2, FT_2N);
    run_case(8'h07, 3'h0, 3'h4, 10'h3C4, 2'h0, 2'h1, 3'h4, FT_3N);
    run_case(8'h07, 3'h3, 3'h0, 10'h3C4, 2'h2, 2'h0, 3'h3, FT_12N);
    run_case(8'h07, 3'h7, 3'h0, 10'h02D, 2'h3, 2'h0, 3'h7, FT_123N);
    run_case(8'h07, 3'h0, 3'h3, 10'h000, 2'h0, 2'h2, 3'h3, FT_12N);
    run_case(8'h07, 3'h1, 3'h0, 10'h078, 2'h0, 2'h0, 3'h0, FT_NONE);
    run_case(8'h27, 3'h1, 3'h0, 10'h05A, 2'h1, 2'h0, 3'h1, FT_1N);
    run_case(8'h00, 3'h1, 3'h0, 10'h000, 2'h0, 2'h0, 3'h0, FT_NONE);
  endtask
  // Ten records were made: count saturates, then the alarm is cleared
  task automatic log_full();
    rd_reg(OFS_STATUS, 32'h00020008, 32'h0002000F);
    wr_reg(OFS_ACLR, 32'h00000001);
    rd_reg(OFS_STATUS, 32'h0, 32'h00020000);
    wr_reg(OFS_RDSEL, 32'h1);
    rd_reg(OFS_TYPE, 32'h18, 32'h1F);
    wr_reg(OFS_RDSEL, 32'h0);
  endtask
  task automatic stage_rec();
    @(posedge ref_clk);
    recordType <= FT_123;
    elapsed_delay_pct <= 8'h64;
    faultAng <= 10'h02D;
    dirMode <= DM_DIR_BACKUP;
    recordReq <= 1'b1;
    @(posedge ref_clk);
    recordReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd_reg(OFS_TYPE, 32'h00641807, 32'hFFFFFFFF);
    rd_reg(OFS_ANG, 32'h1234002D, 32'hFFFFFFFF);
    rd_reg(OFS_TIME, 32'h01020304, 32'hFFFFFFFF);
    rd_reg(OFS_CUR, 32'h01000100, 32'hFFFFFFFF);
  endtask
  // Main sequence
  initial begin
    {rst, clkEn, wr, rd, recordReq} = 5'b11000;
    {addr, wdata, elapsed_delay_pct, faultAng} = '0;
    recordType = FT_NONE;
    dirMode = DM_DIR;
    err_total = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    reg_defaults();
    classify();
    log_full();
    stage_rec();
    print_verdict();
  end
  // Watchdog: the run needs well under 2000 cycles
  initial begin
    #40000;
    err_total++;
    print_verdict();
  end
endmodule

bind efd_earth_fault_logger efd_monitor u_mon (
  .ref_clk, .rst, .rd, .rdata, .residualOc, .efStagePickup, .efEvent, .efAlarm,
  .forward_fault_class, .reverse_fault_class, .faultedPhases);
